/* splf_arm_window.sv */
`timescale 1ns/1ps
`default_nettype none
module splf_arm_window
  import splf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic clk_en,
  input wire logic clr,
  input wire logic arm,
  input wire logic cancel,
  output logic store_open,
  output logic load_open,
  output logic expire
);

  logic active_q;
  logic [2:0] cnt_q;

  // The first cycle after the arming write is cycle one of the window.
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      active_q <= 1'b0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (arm) begin
        active_q <= 1'b1;
        cnt_q <= WIN_FIRST;
      end else if (cancel || expire) begin
        active_q <= 1'b0;
      end else if (active_q) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  assign store_open = active_q && cnt_q <= WIN_STORE;
  assign load_open = active_q && cnt_q <= WIN_LOAD;
  assign expire = active_q && cnt_q == WIN_STORE && !arm && !cancel;

  chk_window_start: assert property (@(posedge clk_sys) disable iff (clr || !clk_en)
    arm |=> (active_q && cnt_q == WIN_FIRST)) else $error("window did not open");

endmodule
`default_nettype wire

/* splf_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module splf_cpu_model
  import splf_pkg::*;
(
  input wire logic clk_sys,
  output var splf_cpu_req_t cpu_req,
  output logic [7:0] flash_rdata
);
  initial cpu_req = '0;
  // Outside a load the flash byte is inverted so a stale value never passes.
  assign flash_rdata = cpu_req.load ? (cpu_req.zptr[7:0] ^ 8'h5A) : ~(cpu_req.zptr[7:0] ^ 8'h5A);
  // Entered just after an edge; the request is held for one edge only.
  task automatic instr(input logic st, input logic [15:0] z, input logic [7:0] d);
    cpu_req.store <= st;
    cpu_req.load <= !st;
    cpu_req.zptr <= z;
    cpu_req.low_data <= d;
    @(posedge clk_sys);
    cpu_req.store <= 1'b0;
    cpu_req.load <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* splf_pkg.sv */
package splf_pkg;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;

  localparam int CTL_EN = 0;
  localparam int CTL_ERASE = 1;
  localparam int CTL_PWRITE = 2;
  localparam int CTL_LOCKSET = 3;
  localparam int CTL_REEN = 4;
  localparam int CTL_BUSY = 6;
  localparam int STAT_PROG = 0;
  localparam int STAT_EEBUSY = 1;
  localparam int STAT_ARMED = 2;
  localparam logic [4:0] CTRL_RST = 5'h00;

  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_PWRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REEN = 5'h11;

  localparam logic [2:0] WIN_STORE = 3'h4;
  localparam logic [2:0] WIN_LOAD = 3'h3;
  localparam logic [2:0] WIN_FIRST = 3'h1;

  localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
  localparam logic [15:0] Z_LOCK = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] RWW_LIMIT = 16'h7000;
  localparam logic [7:0] BLOCKED_DATA = 8'hFF;
  localparam logic [1:0] LOCK_PAD = 2'h3;

  localparam int CLK_MHZ = 100;
  localparam int PROG_MIN_NS = 3700000;
  localparam int PROG_MAX_NS = 4500000;
  localparam int PROG_CYCLES_DFLT = (PROG_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_MAX_CYCLES = (PROG_MAX_NS * CLK_MHZ) / 1000;
  localparam int TMR_W = 20;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_PROG = 2'b11
  } splf_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_LOAD = 3'h1,
    OP_ERASE = 3'h2,
    OP_PWRITE = 3'h3,
    OP_LOCK = 3'h4,
    OP_REEN = 3'h5
  } splf_op_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } splf_avs_req_t;

  typedef struct packed {
    logic store;
    logic load;
    logic [15:0] zptr;
    logic [7:0] low_data;
  } splf_cpu_req_t;

  typedef struct packed {
    logic [7:0] fuse_low;
    logic [7:0] fuse_high;
    logic [7:0] fuse_ext;
    logic [5:0] lock;
  } splf_nv_t;

  function automatic splf_op_t splf_decode(input logic [4:0] b);
    splf_op_t op;
    op = OP_NONE;
    unique case (b)
      CMD_LOAD: op = OP_LOAD;
      CMD_ERASE: op = OP_ERASE;
      CMD_PWRITE: op = OP_PWRITE;
      CMD_LOCK: op = OP_LOCK;
      CMD_REEN: op = OP_REEN;
      default: op = OP_NONE;
    endcase
    return op;
  endfunction

  function automatic logic splf_in_rww(input logic [15:0] z);
    return z < RWW_LIMIT;
  endfunction

endpackage

/* splf_prog_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module splf_prog_timer
  import splf_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_CYCLES_DFLT
) (
  input wire logic clk_sys,
  input wire logic clk_en,
  input wire logic power_on_reset,
  input wire logic start,
  output logic busy_q,
  output logic done_q
);

  localparam logic [TMR_W-1:0] LOAD_VAL = TMR_W'(CYCLES - 1);

  logic [TMR_W-1:0] cnt_q;

  // System reset does not reach this counter, so a write in flight always finishes.
  always_ff @(posedge clk_sys) begin
    if (power_on_reset) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= '0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (!busy_q && start) begin
        busy_q <= 1'b1;
        cnt_q <= LOAD_VAL;
      end else if (busy_q) begin
        if (cnt_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - TMR_W'(1);
        end
      end
    end
  end

  chk_timer_done_end: assert property (@(posedge clk_sys) disable iff (power_on_reset || !clk_en)
    $fell(busy_q) |-> done_q) else $error("timer ended without done pulse");

  chk_timer_start: assert property (@(posedge clk_sys) disable iff (power_on_reset || !clk_en)
    (start && !busy_q) |=> (busy_q && cnt_q == LOAD_VAL)) else $error("timer did not load");

endmodule
`default_nettype wire

/* splf_selfprog.sv */
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module splf_selfprog
  import splf_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic power_on_reset,
  input wire logic clk_en,
  input wire splf_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire splf_cpu_req_t cpu_req,
  input wire logic [7:0] flash_rdata,
  input wire splf_nv_t nv_bits,
  input wire logic eeprom_write_busy_bit,
  output logic [7:0] lpm_data,
  output logic lpm_valid,
  output logic area_busy_flag,
  output logic cpu_halt,
  output logic buf_load,
  output logic buf_erase,
  output logic flash_erase_start,
  output logic flash_write_start,
  output logic [15:0] page_addr,
  output logic lock_wr,
  output logic [5:0] lock_wr_data,
  output logic prog_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  splf_state_t state_q;
  splf_op_t op_q;
  splf_op_t wr_op;
  splf_op_t kind_q;
  logic [4:0] ctrl_q;
  logic area_busy_q;
  logic cpu_halt_q;
  logic waitreq_q;
  logic [31:0] readdata_q;
  logic [7:0] lpm_data_q;
  logic lpm_valid_q;
  logic buf_load_q;
  logic buf_erase_q;
  logic erase_start_q;
  logic write_start_q;
  logic [15:0] page_q;
  logic lock_wr_q;
  logic [5:0] lock_data_q;
  logic sys_clr;
  logic bus_clr;
  logic wr_fire;
  logic ctrl_wr;
  logic ctrl_accept;
  logic store_take;
  logic load_take;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic win_store;
  logic win_load;
  logic win_expire;
  logic win_arm;
  logic win_cancel;
  logic [5:0] lock_new;

  // A system reset that lands mid-write leaves the write engine alone.
  assign sys_clr = power_on_reset || (reset && state_q != ST_PROG);
  assign bus_clr = power_on_reset || reset;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: waitrequest drops one cycle after a request appears.

  assign wr_fire = avs_req.write && !waitreq_q;
  assign ctrl_wr = wr_fire && avs_req.address == ADDR_CTRL && avs_req.byteenable[0];
  assign wr_op = splf_decode(avs_req.writedata[4:0]);
  assign ctrl_accept = clk_en && ctrl_wr && !eeprom_write_busy_bit &&
    state_q != ST_PROG;

  always_ff @(posedge clk_sys) begin
    if (bus_clr) begin
      waitreq_q <= 1'b1;
    end else if (clk_en) begin
      if (!waitreq_q) begin
        waitreq_q <= 1'b1;
      end else if (avs_req.read || avs_req.write) begin
        waitreq_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (bus_clr) begin
      readdata_q <= 32'h00000000;
    end else if (clk_en && waitreq_q && avs_req.read) begin
      unique case (avs_req.address)
        ADDR_CTRL: readdata_q <= {24'h000000, 1'b0, area_busy_q, 1'b0, ctrl_q};
        ADDR_STAT: readdata_q <= {29'h00000000, state_q == ST_ARMED,
          eeprom_write_busy_bit, tmr_busy};
        default: readdata_q <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arming window and write timer.

  assign win_arm = ctrl_accept && wr_op != OP_NONE;
  assign win_cancel = store_take || load_take || (ctrl_accept && wr_op == OP_NONE);

  splf_arm_window u_window (
    .clk_sys(clk_sys),
    .clk_en(clk_en),
    .clr(sys_clr),
    .arm(win_arm),
    .cancel(win_cancel),
    .store_open(win_store),
    .load_open(win_load),
    .expire(win_expire)
  );

  // Store needs the open window; EEPROM activity vetoes any programming step.
  assign store_take = clk_en && cpu_req.store && win_store && state_q == ST_ARMED &&
    !eeprom_write_busy_bit;
  assign load_take = clk_en && cpu_req.load && win_load && state_q == ST_ARMED &&
    op_q == OP_LOCK && !eeprom_write_busy_bit;
  assign tmr_start = store_take && (op_q == OP_ERASE || op_q == OP_PWRITE ||
    op_q == OP_LOCK);

  splf_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .clk_en(clk_en),
    .power_on_reset(power_on_reset),
    .start(tmr_start),
    .busy_q(tmr_busy),
    .done_q(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register and sequencer state.

  always_ff @(posedge clk_sys) begin
    if (sys_clr) begin
      ctrl_q <= CTRL_RST;
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
    end else if (clk_en) begin
      if (tmr_done) begin
        ctrl_q <= CTRL_RST;
        state_q <= ST_IDLE;
      end else if (ctrl_accept) begin
        ctrl_q <= (wr_op == OP_NONE) ? CTRL_RST : avs_req.writedata[4:0];
        state_q <= (wr_op == OP_NONE) ? ST_IDLE : ST_ARMED;
        op_q <= wr_op;
      end else if (tmr_start) begin
        state_q <= ST_PROG;
      end else if (store_take || load_take) begin
        ctrl_q <= CTRL_RST;
        state_q <= ST_IDLE;
      end else if (win_expire && state_q == ST_ARMED) begin
        ctrl_q <= CTRL_RST;
        state_q <= ST_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Area busy flag and flash strobes.

  // Lock writes never set the flag, so the whole flash stays readable then.
  always_ff @(posedge clk_sys) begin
    if (sys_clr) begin
      area_busy_q <= 1'b0;
    end else if (clk_en) begin
      if (tmr_start && op_q != OP_LOCK && splf_in_rww(cpu_req.zptr)) begin
        area_busy_q <= 1'b1;
      end else if (store_take && op_q == OP_REEN && !tmr_busy) begin
        area_busy_q <= 1'b0;
      end else if (store_take && op_q == OP_LOAD) begin
        area_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_clr) begin
      buf_load_q <= 1'b0;
      buf_erase_q <= 1'b0;
      erase_start_q <= 1'b0;
      write_start_q <= 1'b0;
    end else if (clk_en) begin
      buf_load_q <= store_take && op_q == OP_LOAD;
      buf_erase_q <= store_take && op_q == OP_REEN && !tmr_busy;
      erase_start_q <= tmr_start && op_q == OP_ERASE;
      write_start_q <= tmr_start && op_q == OP_PWRITE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write engine: survives system reset until the timer ends.

  // The pointer is ignored for lock writes; only low data bits 5..0 matter.
  assign lock_new = nv_bits.lock & cpu_req.low_data[5:0];

  always_ff @(posedge clk_sys) begin
    if (power_on_reset) begin
      kind_q <= OP_NONE;
      page_q <= 16'h0000;
      lock_data_q <= 6'h3F;
      cpu_halt_q <= 1'b0;
      lock_wr_q <= 1'b0;
    end else if (clk_en) begin
      lock_wr_q <= tmr_done && kind_q == OP_LOCK;
      if (tmr_start) begin
        kind_q <= op_q;
        if (op_q == OP_LOCK) begin
          lock_data_q <= lock_new;
        end else begin
          page_q <= cpu_req.zptr;
          cpu_halt_q <= !splf_in_rww(cpu_req.zptr);
        end
      end else if (tmr_done) begin
        cpu_halt_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program-memory load answers.

  always_ff @(posedge clk_sys) begin
    if (sys_clr) begin
      lpm_valid_q <= 1'b0;
      lpm_data_q <= 8'h00;
    end else if (clk_en) begin
      lpm_valid_q <= cpu_req.load;
      if (load_take) begin
        // Stored values are already active low: programmed reads as zero.
        unique case (cpu_req.zptr)
          Z_FUSE_LOW: lpm_data_q <= nv_bits.fuse_low;
          Z_LOCK: lpm_data_q <= {LOCK_PAD, nv_bits.lock};
          Z_FUSE_EXT: lpm_data_q <= nv_bits.fuse_ext;
          Z_FUSE_HIGH: lpm_data_q <= nv_bits.fuse_high;
          default: lpm_data_q <= BLOCKED_DATA;
        endcase
      end else if (cpu_req.load) begin
        lpm_data_q <= (area_busy_q && splf_in_rww(cpu_req.zptr)) ?
          BLOCKED_DATA : flash_rdata;
      end
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitreq_q;
  assign lpm_data = lpm_data_q;
  assign lpm_valid = lpm_valid_q;
  assign area_busy_flag = area_busy_q;
  assign cpu_halt = cpu_halt_q;
  assign buf_load = buf_load_q;
  assign buf_erase = buf_erase_q;
  assign flash_erase_start = erase_start_q;
  assign flash_write_start = write_start_q;
  assign page_addr = page_q;
  assign lock_wr = lock_wr_q;
  assign lock_wr_data = lock_data_q;
  assign prog_busy = tmr_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [5:0] lock_new_d1;
  logic [7:0] fuse_low_d1;
  always_ff @(posedge clk_sys) begin
    lock_new_d1 <= lock_new;
    fuse_low_d1 <= nv_bits.fuse_low;
  end

  sequence s_lock_armed;
    ctrl_accept && wr_op == OP_LOCK;
  endsequence

  sequence s_idle_four;
    (clk_en && !cpu_req.store && !cpu_req.load)[*4];
  endsequence

  chk_rww_read_block: assert property (@(posedge clk_sys) disable iff (bus_clr || !clk_en)
    (cpu_req.load && !load_take && area_busy_q && splf_in_rww(cpu_req.zptr))
    |=> (lpm_valid_q && lpm_data_q == BLOCKED_DATA)) else $error("busy area read not blocked");

  chk_busy_on_erase: assert property (@(posedge clk_sys) disable iff (bus_clr || !clk_en)
    (tmr_start && op_q == OP_ERASE && splf_in_rww(cpu_req.zptr)) |=> area_busy_q [*2])
    else $error("busy flag not held after erase start");

  chk_reenable_clears: assert property (@(posedge clk_sys) disable iff (bus_clr || !clk_en)
    (store_take && op_q == OP_REEN && !tmr_busy) |=> (!area_busy_q && buf_erase_q))
    else $error("re-enable did not clear busy flag");

  chk_lock_data: assert property (@(posedge clk_sys) disable iff (power_on_reset || !clk_en)
    (tmr_start && op_q == OP_LOCK) |=> (lock_data_q == lock_new_d1 && tmr_busy))
    else $error("lock data not captured");

  chk_lock_readable: assert property (@(posedge clk_sys) disable iff (bus_clr || !clk_en)
    (tmr_start && op_q == OP_LOCK) |=> (area_busy_q == $past(area_busy_q) && !cpu_halt_q))
    else $error("lock write blocked flash");

  chk_eeprom_blocks: assert property (@(posedge clk_sys) disable iff (bus_clr || !clk_en)
    (ctrl_wr && eeprom_write_busy_bit && state_q == ST_IDLE) |=> state_q == ST_IDLE)
    else $error("arming accepted during EEPROM write");

  chk_arm_expire: assert property (@(posedge clk_sys) disable iff (bus_clr)
    s_lock_armed ##1 s_idle_four |=> (state_q == ST_IDLE && ctrl_q == CTRL_RST))
    else $error("arming did not time out");

  chk_fuse_low_read: assert property (@(posedge clk_sys) disable iff (bus_clr || !clk_en)
    (load_take && cpu_req.zptr == Z_FUSE_LOW) |=> (lpm_data_q == fuse_low_d1 && ctrl_q == CTRL_RST))
    else $error("fuse low byte not returned");

  chk_done_clears_en: assert property (@(posedge clk_sys) disable iff (power_on_reset || !clk_en)
    tmr_done |=> (!ctrl_q[CTL_EN] && state_q == ST_IDLE))
    else $error("enable bit not cleared at completion");

  chk_load_clears: assert property (@(posedge clk_sys) disable iff (bus_clr || !clk_en)
    (store_take && op_q == OP_LOAD) |=> (!area_busy_q && buf_load_q))
    else $error("buffer load did not clear busy flag");

endmodule
`default_nettype wire

/* splf_selfprog_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module splf_selfprog_tb;
  import splf_pkg::*;
  localparam int unsigned PC = 20;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic power_on_reset = 1'b1;
  logic ee_busy = 1'b0;
  logic clk_en = 1'b1;
  logic cpu_halt;
  logic buf_load;
  logic buf_erase;
  logic flash_erase_start;
  logic flash_write_start;
  logic [15:0] page_addr;
  splf_avs_req_t req = '0;
  splf_nv_t nv = '0;
  splf_cpu_req_t cpu_req;
  logic [7:0] flash_rdata;
  logic [7:0] lpm_data;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic avs_waitrequest;
  logic lpm_valid;
  logic area_busy_flag;
  logic lock_wr;
  logic prog_busy;
  logic [5:0] lock_wr_data;
  logic [31:0] rnd = 32'hBE71D0AC;
  int n_errors = 0;
  int check_count = 0;

  always #5 clk_sys = ~clk_sys;

  splf_cpu_model u_cpu (.clk_sys(clk_sys), .cpu_req(cpu_req), .flash_rdata(flash_rdata));

  splf_selfprog #(.PROG_CYCLES(PC)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .power_on_reset(power_on_reset), .clk_en(clk_en),
    .avs_req(req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_req(cpu_req), .flash_rdata(flash_rdata), .nv_bits(nv),
    .eeprom_write_busy_bit(ee_busy), .lpm_data(lpm_data), .lpm_valid(lpm_valid),
    .area_busy_flag(area_busy_flag), .cpu_halt(cpu_halt), .buf_load(buf_load),
    .buf_erase(buf_erase), .flash_erase_start(flash_erase_start),
    .flash_write_start(flash_write_start), .page_addr(page_addr), .lock_wr(lock_wr),
    .lock_wr_data(lock_wr_data), .prog_busy(prog_busy)
  );

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] exp_rd(input logic [15:0] z);
    case (z)
      16'h0000: return nv.fuse_low;
      16'h0001: return {2'b11, nv.lock};
      16'h0002: return nv.fuse_ext;
      default: return nv.fuse_high;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    req.address <= a;
    req.write <= w;
    req.read <= !w;
    req.writedata <= {24'h0, d};
    req.byteenable <= 4'hF;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) check("waitrequest", 32'h1, 32'h0);
    q = avs_readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    // One idle edge between requests, so no strobe is driven twice in a time step.
    @(posedge clk_sys);
  endtask

  task automatic lpm(input logic [15:0] z, input logic [7:0] e);
    u_cpu.instr(1'b0, z, 8'h00);
    @(posedge clk_sys);
    check("lpm_valid", {31'h0, lpm_valid}, 32'h1);
    check("lpm_data", {24'h0, lpm_data}, {24'h0, e});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(ADDR_CTRL, 1'b0, 8'h00);
      n++;
    end while (q[0] !== 1'b0 && n < 200);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end

  initial begin
    int n;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    power_on_reset <= 1'b0;
    @(posedge clk_sys);
    bus(ADDR_CTRL, 1'b0, 8'h00);
    check("ctrl reset", q, 32'h0);
    bus(4'h8, 1'b1, 8'hFF);
    bus(4'h8, 1'b0, 8'h00);
    check("unmapped", q, 32'h0);
    bus(ADDR_STAT, 1'b0, 8'h00);
    check("stat reset", q, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      nv <= rnd[29:0];
      @(posedge clk_sys);
      bus(ADDR_CTRL, 1'b1, CMD_LOCK);
      lpm(i[15:0], exp_rd(i[15:0]));
      bus(ADDR_CTRL, 1'b0, 8'h00);
      check("arm cleared", q, 32'h0);
    end
    // A low clock enable freezes the window, so the readout still lands.
    bus(ADDR_CTRL, 1'b1, CMD_LOCK);
    clk_en <= 1'b0;
    repeat (6) @(posedge clk_sys);
    clk_en <= 1'b1;
    lpm(16'h0001, exp_rd(16'h0001));
    lpm(16'h0123, 8'h23 ^ 8'h5A);
    bus(ADDR_CTRL, 1'b1, CMD_LOCK);
    repeat (2) @(posedge clk_sys);
    lpm(16'h0001, 8'h01 ^ 8'h5A);
    $display("test readout done");
    // A store one cycle past the window must not start anything.
    bus(ADDR_CTRL, 1'b1, CMD_LOCK);
    repeat (3) @(posedge clk_sys);
    u_cpu.instr(1'b1, 16'h0001, 8'hC0);
    bus(ADDR_STAT, 1'b0, 8'h00);
    check("late store", q, 32'h0);
    rnd = lfsr(rnd);
    bus(ADDR_CTRL, 1'b1, CMD_LOCK); // EEPROM is idle here.
    repeat (2) @(posedge clk_sys);
    u_cpu.instr(1'b1, 16'h0001, {2'b11, rnd[5:0]});
    @(posedge clk_sys);
    lpm(16'h0100, 8'h00 ^ 8'h5A);
    n = 0;
    while (lock_wr !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    check("lock pulse", {31'h0, lock_wr}, 32'h1);
    check("lock data", {26'h0, lock_wr_data}, {26'h0, nv.lock & rnd[5:0]});
    wait_idle();
    check("lock end", q, 32'h0);
    $display("test lock write done");
    bus(ADDR_CTRL, 1'b1, CMD_ERASE);
    u_cpu.instr(1'b1, 16'h0200, 8'h00);
    @(posedge clk_sys);
    check("erase strobe", {31'h0, flash_erase_start}, 32'h1);
    check("erase page", {16'h0, page_addr}, 32'h200);
    check("no halt", {31'h0, cpu_halt}, 32'h0);
    lpm(16'h0200, 8'hFF);
    bus(ADDR_CTRL, 1'b1, CMD_REEN);
    bus(ADDR_CTRL, 1'b0, 8'h00);
    check("ctrl busy", q, 32'h43);
    wait_idle();
    check("ctrl done", q, 32'h40);
    bus(ADDR_CTRL, 1'b1, CMD_REEN);
    u_cpu.instr(1'b1, 16'h0000, 8'h00);
    @(posedge clk_sys);
    check("buffer erase", {31'h0, buf_erase}, 32'h1);
    @(posedge clk_sys);
    check("reenable", {31'h0, area_busy_flag}, 32'h0);
    $display("test erase done");
    // A system reset in mid-write must not shorten the write.
    // The bench stays off the busy area while the write runs.
    bus(ADDR_CTRL, 1'b1, CMD_PWRITE);
    u_cpu.instr(1'b1, 16'h0300, 8'h00);
    n = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      if (prog_busy === 1'b1) n++;
      if (k == 0) check("write strobe", {31'h0, flash_write_start}, 32'h1);
      if (k == 0) check("write page", {16'h0, page_addr}, 32'h300);
      if (k == 4) reset <= 1'b1;
      if (k == 6) reset <= 1'b0;
    end
    check("write length", n, PC);
    wait_idle();
    // An erase of the blocked area halts the core but leaves the busy flag alone.
    bus(ADDR_CTRL, 1'b1, CMD_ERASE);
    u_cpu.instr(1'b1, 16'h7100, 8'h00);
    @(posedge clk_sys);
    check("halt", {31'h0, cpu_halt}, 32'h1);
    check("busy kept", {31'h0, area_busy_flag}, 32'h1);
    wait_idle();
    check("halt end", {31'h0, cpu_halt}, 32'h0);
    bus(ADDR_CTRL, 1'b1, CMD_LOAD);
    u_cpu.instr(1'b1, 16'h0000, 8'h00);
    @(posedge clk_sys);
    check("buffer load", {31'h0, buf_load}, 32'h1);
    @(posedge clk_sys);
    check("load clears", {31'h0, area_busy_flag}, 32'h0);
    $display("test write and reset done");
    ee_busy <= 1'b1;
    @(posedge clk_sys);
    bus(ADDR_CTRL, 1'b1, CMD_LOCK);
    bus(ADDR_CTRL, 1'b0, 8'h00);
    check("ee blocks ctrl", q, 32'h0);
    u_cpu.instr(1'b1, 16'h0001, 8'hC0);
    bus(ADDR_STAT, 1'b0, 8'h00);
    check("ee blocks prog", q, 32'h2);
    ee_busy <= 1'b0;
    // EEPROM activity that starts after arming still refuses the readout.
    bus(ADDR_CTRL, 1'b1, CMD_LOCK);
    ee_busy <= 1'b1;
    lpm(16'h0001, 8'h01 ^ 8'h5A);
    ee_busy <= 1'b0;
    $display("test eeprom interlock done");
    wrap_up();
  end
endmodule
`default_nettype wire
